// >>> src/dual_mode_host_port.sv
`timescale 1ns/1ps
// Function
// R01 - mode pin picks separate or single strobes
// R02 - write strobe rise captures data under select
// R03 - single strobe rise captures data when writing
// R04 - direction high reads while strobe is low
// R05 - read and select low drive data
// R06 - host holds select like address lines; single mode decode ignores select
// R07 - data bus sixteen bits, bit fifteen top
// R08 - address bus three bits, bit two top
// R09 - host may read channel output data
// R10 - updates applied on one processing clock edge
// R11 - bus released whenever no read active
module dual_mode_host_port
  import host_port_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // host pins
  input wire logic host_mode_i,
  input wire logic host_chip_sel_n_i,
  input wire logic [AW-1:0] host_addr_i, // R08
  input wire logic host_wr_strobe_n_i,
  input wire logic host_rd_n_i,
  input wire logic [DW-1:0] host_data_i, // R07
  output logic [DW-1:0] host_data_o, // R07
  output logic host_data_oe_o,
  // core side: read data per location, write update
  input wire logic [LOC_N*DW-1:0] core_rd_data_i,
  output logic [DW-1:0] core_wr_data_o,
  output logic [AW-1:0] core_wr_addr_o,
  output logic core_wr_stb_o,
  output logic [AW-1:0] core_rd_addr_o,
  output logic core_rd_stb_o
);
  // pin bundle through the three-stage synchroniser
  // one bundle keeps every pin on the same delay, so a strobe never outruns its data
  localparam int PW = 3 + AW + DW + 1;
  localparam logic [PW-1:0] PIN_RST = {1'b1, 1'b1, 1'b1, {AW{1'b0}}, {DW{1'b0}},
                                       MODE_SEPARATE};
  logic [PW-1:0] pins_sync;
  pin_sync #(.WIDTH(PW), .RST_VAL(PIN_RST)) pin_sync_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i({host_chip_sel_n_i, host_wr_strobe_n_i, host_rd_n_i, host_addr_i,
              host_data_i, host_mode_i}),
    .sync_o(pins_sync)
  );
  // unpacked synchronised pins
  wire cs_n = pins_sync[PW-1];
  wire wr_n = pins_sync[PW-2];
  wire rd_n = pins_sync[PW-3]; // read strobe, or direction in single mode
  wire [AW-1:0] addr = pins_sync[DW+AW:DW+1];
  wire [DW-1:0] data = pins_sync[DW:1];
  wire mode = pins_sync[0];

  // decode of the strobe scheme
  function automatic logic wr_active(input logic m, input logic c, input logic w,
                                     input logic r);
    // separate: write strobe low under select; single: strobe low, direction write
    wr_active = (m == MODE_SEPARATE) ? (!w && !c) : (!w && (r != DIR_READ)); // R01
  endfunction
  function automatic logic rd_active(input logic m, input logic c, input logic w,
                                     input logic r);
    rd_active = (m == MODE_SEPARATE) ? (!r && !c) : (!w && (r == DIR_READ)); // R01
  endfunction

  // live decode of the synchronised pins
  wire wr_now = wr_active(mode, cs_n, wr_n, rd_n);
  wire rd_now = rd_active(mode, cs_n, wr_n, rd_n);

  // port state and capture registers
  port_state_t state;
  port_state_t next_state;
  logic [DW-1:0] hold_data; // write holding register
  logic [AW-1:0] hold_addr;
  logic [DW-1:0] wr_data_q;
  logic [AW-1:0] wr_addr_q;

  // write ends on strobe rise: leaving write state captures
  wire wr_rise = (state == ST_WRITE) && !wr_now; // R02 R03
  wire [DW-1:0] rd_word = core_rd_data_i[addr*DW +: DW]; // R09

  // state transitions
  always_comb begin
    case (state)
      ST_IDLE: next_state = wr_now ? ST_WRITE : (rd_now ? ST_READ : ST_IDLE);
      ST_WRITE: next_state = wr_now ? ST_WRITE : ST_IDLE;
      ST_READ: next_state = rd_now ? ST_READ : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // state, holding register and core strobes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      hold_data <= DATA_RST;
      hold_addr <= ADDR_RST;
      wr_data_q <= DATA_RST;
      wr_addr_q <= ADDR_RST;
      core_wr_stb_o <= 1'b0;
      core_rd_stb_o <= 1'b0;
      core_rd_addr_o <= ADDR_RST;
    end else if (ce_i) begin
      state <= next_state;
      // track bus while strobe low; last value is the rising-edge value
      if (wr_now) begin
        hold_data <= data; // R02 R03
        hold_addr <= addr;
      end
      // one clean update pulse on the processing clock
      core_wr_stb_o <= wr_rise; // R10
      if (wr_rise) begin
        wr_data_q <= hold_data;
        wr_addr_q <= hold_addr;
      end
      core_rd_stb_o <= (state == ST_IDLE) && rd_now; // R09
      if (rd_now) begin
        core_rd_addr_o <= addr;
      end
    end
  end

  assign core_wr_data_o = wr_data_q;
  assign core_wr_addr_o = wr_addr_q;

  // data bus drive; oe only during a read, else released
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_o <= DATA_RST;
      host_data_oe_o <= 1'b0;
    end else if (ce_i) begin
      host_data_oe_o <= rd_now; // R04 R05 R11
      host_data_o <= rd_now ? rd_word : DATA_RST; // R04 R05
    end
  end

  // a write may not overlap a drive of the bus
  no_contend_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
    (ce_i && wr_now) |=> !host_data_oe_o)
    else $error("data bus driven during write");
  read_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R05
    (ce_i && mode == MODE_SEPARATE && !rd_n && !cs_n) |=> host_data_oe_o)
    else $error("separate read not driven");
  single_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
    (ce_i && mode == MODE_SINGLE && !wr_n && rd_n) |=>
    (host_data_oe_o && host_data_o == $past(rd_word)))
    else $error("single strobe read wrong");
  sep_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R02
    (ce_i && state == ST_WRITE && mode == MODE_SEPARATE && wr_n) |=> core_wr_stb_o)
    else $error("write edge not taken");
  sel_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R02
    (ce_i && state == ST_IDLE && mode == MODE_SEPARATE && cs_n) |=> state != ST_WRITE)
    else $error("write without select");
  single_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R03
    (ce_i && wr_rise) |=> (core_wr_data_o == $past(hold_data) && core_wr_stb_o))
    else $error("single write data lost");
  upd_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    (ce_i && core_wr_stb_o) |=> !core_wr_stb_o)
    else $error("update pulse too long");
  mode_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R01
    (ce_i && mode == MODE_SINGLE && wr_n) |=> !host_data_oe_o)
    else $error("single mode drive without strobe");

  // refusals and drive contents
  sel_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R05
    (ce_i && mode == MODE_SEPARATE && cs_n) |=>
    !host_data_oe_o)
    else $error("separate read without select driven");
  drive_data_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
    (ce_i && rd_now) |=>
    (host_data_o == $past(rd_word)))
    else $error("read word not from addressed location");
  release_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
    !host_data_oe_o |->
    (host_data_o == DATA_RST))
    else $error("released bus left holding data");
  rd_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R08
    (ce_i && rd_now) |=>
    (core_rd_addr_o == $past(addr)))
    else $error("read address not passed to core");

  // capture and core update
  hold_track_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R02 R03
    (ce_i && wr_now) |=>
    (hold_data == $past(data)))
    else $error("holding register missed bus value");
  wr_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R08
    (ce_i && wr_rise) |=>
    (core_wr_addr_o == $past(hold_addr)))
    else $error("write address lost");
  upd_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    core_wr_stb_o |->
    (state != ST_WRITE))
    else $error("update pulse inside write");
  rd_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
    (ce_i && core_rd_stb_o) |=>
    !core_rd_stb_o)
    else $error("read pulse too long");

  // clock enable low holds every register; a frozen port must not drift
  freeze_bus_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ce_i |=>
    ($stable(host_data_oe_o) && $stable(host_data_o)))
    else $error("bus drive moved while frozen");
  freeze_state_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ce_i |=>
    ($stable(state) && $stable(hold_data)))
    else $error("port state moved while frozen");
  freeze_core_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ce_i |=>
    ($stable(core_wr_stb_o) && $stable(core_rd_stb_o)))
    else $error("core strobes moved while frozen");
  state_onehot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i |->
    $onehot(state))
    else $error("port state not one-hot");
endmodule // dual_mode_host_port

// >>> src/host_port_pkg.sv
package host_port_pkg;
  // bus widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int LOC_N = 8;
  // depth of the pin synchroniser
  localparam int SYNC_STAGES = 3;
  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [2:0] ADDR_RST = 3'h0;
  // strobe scheme selected by the mode pin
  localparam logic MODE_SEPARATE = 1'b0;
  localparam logic MODE_SINGLE = 1'b1;
  // direction input level meaning read
  localparam logic DIR_READ = 1'b1;
  // one-hot port states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } port_state_t;
endpackage

// >>> src/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // asynchronous input and filtered result
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta; // first stage, read only by stage two
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  // bitwise agreement of the two later stages
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_sync = (agree & stage3) | (~agree & sync_o);

  // shift chain
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      sync_o <= RST_VAL;
    end else if (ce_i) begin
      meta <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end
endmodule // pin_sync

// >>> verification/host_model.sv
`timescale 1ns/1ps
// host side: pins change after an edge and stand until the host closes
module host_model (
  // clock
  input wire logic mclk_i,
  // device answer
  input wire logic [15:0] dev_data_i,
  input wire logic dev_oe_i,
  // host pins
  output logic mode_o,
  output logic cs_n_o,
  output logic [2:0] addr_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [15:0] data_o
);
  logic drv = 1'b0; // host owns the bus
  logic [15:0] val = 16'h0000; // last host value
  // released bus shows the inverse, so a stale value never matches
  assign data_o = dev_oe_i ? dev_data_i : (drv ? val : ~val);
  // idle: strobes high, chip not selected
  initial begin
    mode_o = 1'b0;
    cs_n_o = 1'b1;
    addr_o = 3'h0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
  end
  // open a transfer with strobe low and all qualifiers set
  task automatic open_xfer(input logic m, input logic c, input logic w, input logic r,
    input logic [2:0] a, input logic [15:0] d, input logic dv);
    @(posedge mclk_i);
    mode_o <= m;
    cs_n_o <= c;
    addr_o <= a;
    wr_n_o <= w;
    rd_n_o <= r;
    val <= d;
    drv <= dv;
  endtask
  // raise the strobe, hold the rest well past the rise
  task automatic close_xfer();
    @(posedge mclk_i);
    wr_n_o <= 1'b1;
    if (!mode_o) rd_n_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    drv <= 1'b0;
  endtask
endmodule // host_model

// >>> verification/test_dual_mode_host_port.sv
`timescale 1ns/1ps
// scenario bench for the dual strobe host port
module test_dual_mode_host_port;
  import host_port_pkg::*;
  logic mclk = 1'b0; // 40 MHz
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [127:0] core_rd = 128'h7e17_6d26_5c35_4b44_3a53_2962_1871_0780;
  logic mode, cs_n, wr_n, rd_n, oe, wstb, rstb, hit;
  logic [2:0] addr, waddr, raddr;
  logic [15:0] din, dout, wdata;
  int err_count = 0;
  int n_tests = 0;
  always #12.5 mclk = ~mclk;
  host_model host_model_i (.mclk_i(mclk), .dev_data_i(dout), .dev_oe_i(oe), .mode_o(mode),
    .cs_n_o(cs_n), .addr_o(addr), .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(din));
  dual_mode_host_port dual_mode_host_port_i (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce),
    .host_mode_i(mode), .host_chip_sel_n_i(cs_n), .host_addr_i(addr),
    .host_wr_strobe_n_i(wr_n), .host_rd_n_i(rd_n), .host_data_i(din), .host_data_o(dout),
    .host_data_oe_o(oe), .core_rd_data_i(core_rd), .core_wr_data_o(wdata),
    .core_wr_addr_o(waddr), .core_wr_stb_o(wstb), .core_rd_addr_o(raddr),
    .core_rd_stb_o(rstb));
  // one comparison, reported at once on mismatch
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // bounded wait for the update pulse or the bus drive
  task automatic wait_sig(input bit rd);
    hit = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      #1;
      if ((rd ? oe : wstb) === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask
  // write cycle; sel tells whether the device should take it
  task automatic do_write(input logic m, input logic c, input logic [2:0] a,
    input logic [15:0] d, input logic sel);
    host_model_i.open_xfer(m, c, 1'b0, m ? 1'b0 : 1'b1, a, d, 1'b1);
    repeat (6) @(posedge mclk);
    fork
      host_model_i.close_xfer();
      wait_sig(1'b0);
    join_any
    check("write pulse", {15'h0, sel}, {15'h0, hit});
    if (sel) begin
      check("write data", d, wdata);
      check("write addr", {13'h0, a}, {13'h0, waddr});
    end
    wait fork;
  endtask
  // read cycle; word must appear while strobe is low, bus freed after
  task automatic do_read(input logic m, input logic [2:0] a);
    host_model_i.open_xfer(m, 1'b0, m ? 1'b0 : 1'b1, m ? 1'b1 : 1'b0, a, 16'h0, 1'b0);
    wait_sig(1'b1);
    check("read drive", 16'h1, {15'h0, hit});
    check("read data", core_rd[a*16+:16], dout);
    check("read pop", 16'h1, {15'h0, rstb});
    check("read addr", {13'h0, a}, {13'h0, raddr});
    host_model_i.close_xfer();
    check("bus free", 16'h0, {15'h0, oe});
  endtask
  // separate read with select high is refused; bus stays released
  task automatic do_unsel_read(input logic [2:0] a);
    host_model_i.open_xfer(MODE_SEPARATE, 1'b1, 1'b1, 1'b0, a, 16'h0, 1'b0);
    wait_sig(1'b1);
    check("unselected drive", 16'h0, {15'h0, hit});
    host_model_i.close_xfer();
  endtask
  // clock enable low freezes the port; the read goes on once it returns
  task automatic do_freeze(input logic [2:0] a);
    @(posedge mclk);
    ce <= 1'b0;
    host_model_i.open_xfer(MODE_SEPARATE, 1'b0, 1'b1, 1'b0, a, 16'h0, 1'b0);
    repeat (10) @(posedge mclk);
    #1;
    check("frozen drive", 16'h0, {15'h0, oe});
    @(posedge mclk);
    ce <= 1'b1;
    wait_sig(1'b1);
    check("thawed drive", 16'h1, {15'h0, hit});
    check("thawed data", core_rd[a*16+:16], dout);
    host_model_i.close_xfer();
    check("thawed free", 16'h0, {15'h0, oe});
  endtask
  // verdict and end of run
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: scenarios need well under 400 cycles
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
  // reset, then each scenario in turn
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    do_write(MODE_SEPARATE, 1'b0, 3'h5, 16'ha5c3, 1'b1);
    do_write(MODE_SEPARATE, 1'b1, 3'h1, 16'h0ff0, 1'b0);
    do_read(MODE_SEPARATE, 3'h3);
    do_unsel_read(3'h2);
    do_freeze(3'h4);
    do_write(MODE_SINGLE, 1'b1, 3'h6, 16'h3c5a, 1'b1);
    do_read(MODE_SINGLE, 3'h7);
    complete_run();
  end
endmodule // test_dual_mode_host_port
